// ==== hdl/mitl_defines.svh ====
// Offsets, field positions, reset values and timing counts of the terminal logic
`ifndef MITL_DEFINES_SVH
`define MITL_DEFINES_SVH
`define MITL_OFF_CMD 8'h00
`define MITL_OFF_CFG 8'h04
`define MITL_OFF_COUNT 8'h08
`define MITL_OFF_STATUS 8'h0C
`define MITL_OFF_GPIO 8'h10
`define MITL_CMD_START 0
`define MITL_CMD_STOP 1
`define MITL_CMD_EMIT 2
`define MITL_CFG_RESET 32'h0000_0000
`define MITL_COUNT_RESET 32'h0000_0000
`define MITL_GPIO_RESET 32'h0000_0000
`define MITL_KIND_NORMAL 3'h0
`define MITL_KIND_HOME1 3'h1
`define MITL_KIND_HOME2 3'h2
`define MITL_KIND_LEAVE 3'h3
`define MITL_KIND_TIMER 3'h4
`define MITL_CLK_MHZ 20
`define MITL_GO_FILT_CYC 5
`define MITL_GO_PULSE_NS 1000
`define MITL_GO_PULSE_CYC ((`MITL_GO_PULSE_NS * `MITL_CLK_MHZ + 999) / 1000)
`define MITL_CLR_PULSE_NS 10000
`define MITL_CLR_PULSE_CYC ((`MITL_CLR_PULSE_NS * `MITL_CLK_MHZ + 999) / 1000)
`endif

// ==== hdl/mitl_pkg.sv ====
// Types shared by the terminal logic
package mitl_pkg;
	typedef enum logic [1:0] {
		MITL_IDLE = 2'b00,
		MITL_WAIT_GO = 2'b01,
		MITL_RUN = 2'b10,
		MITL_SETTLE = 2'b11
	} mitl_state_e;
	typedef struct packed {
		logic inpos_wait;
		logic settled_pin_polarity;
		logic clear_pin_polarity;
		logic shared_pin_role_select;
		logic [2:0] pulse_format_field;
		logic home_pin_polarity;
		logic halt_pin_polarity;
		logic halt_style_select;
		logic halt_pin_enable;
		logic sync_launch_enable;
		logic dir_minus;
		logic [2:0] operation_kind_field;
	} mitl_cfg_s;
endpackage

// ==== hdl/mitl_terminal.sv ====
// Motion terminal logic: limit, home, go, halt inputs and drive outputs
// Notes on behaviour
// - Limit in moving direction stops pulses at once; stays stopped.
// - Start refused when limit for commanded direction already active.
// - Timer kind ignores both travel limits.
// - Polarity pin low means limit active high, high means active low.
// - Kinds 1 and 2 stop on home inactive-to-active edge, stay stopped.
// - Home stop is edge based; home active at start stops only after a new edge.
// - Kind 3 stops when home goes inactive; refuses start if inactive.
// - Sync enable plus start waits for go pin falling edge.
// - Go pin low shorter than five clocks is ignored.
// - Go pin is open drain; emit command drives one-shot low pulse.
// - Halt pin has enable, immediate/decelerate style and polarity bits.
// - Halt release keeps motor stopped; start during halt refused.
// - Drive style pin picks pulse/dir/gp/settle or four phases/half step.
// - Pulse format field selects one of eight output encodings.
// - Timer kind masks pulses, drives direction, freezes phase sequence.
// - Role select picks deviation clear or current cutback; polarity bit.
// - Scheme pin low gives unipolar, high gives bipolar phase pattern.
// - Half step pin low full step, high half step; advances per pulse.
// - Optional wait for settled input after pulses; its polarity set.
// - GP I/O pins zero and one each have their own direction bit; gp two and three are outputs only.
// - Status word shows live pin levels and phase outputs.
`timescale 1ns/1ps
`default_nettype none
`include "mitl_defines.svh"
module mitl_terminal (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic step_in,
	input wire logic ramp_done_in,
	output logic decel_req_out,
	output logic busy_out,
	input wire logic plus_limit_switch_in,
	input wire logic minus_limit_switch_in,
	input wire logic plus_limit_polarity_pin_in,
	input wire logic minus_limit_polarity_pin_in,
	input wire logic home_switch_in,
	input wire logic ext_go_pin_in,
	output logic ext_go_pin_out,
	output logic ext_go_pin_oe_out,
	input wire logic halt_request_pin_in,
	input wire logic drive_style_pin_in,
	input wire logic polarity_scheme_pin_in,
	input wire logic settle_or_half_in,
	output logic pulse_or_phase_a_out,
	output logic dir_or_phase_b_out,
	output logic gp_two_or_phase_c_out,
	output logic gp_three_or_phase_d_out,
	output logic shared_role_pin_out,
	input wire logic gp_io_zero_in,
	output logic gp_io_zero_out,
	output logic gp_io_zero_oe_out,
	input wire logic gp_io_one_in,
	output logic gp_io_one_out,
	output logic gp_io_one_oe_out
);
	import mitl_pkg::*;

	localparam int SYNC_W = 12;
	localparam logic [3:0] FILT_MAX = 4'(`MITL_GO_FILT_CYC);
	localparam logic [7:0] GO_PULSE = 8'(`MITL_GO_PULSE_CYC);
	localparam logic [7:0] CLR_PULSE = 8'(`MITL_CLR_PULSE_CYC);

	// Pattern index steps through eight half steps of a two-phase motor
	function automatic logic [3:0] phase_pattern(input logic [2:0] idx,
		input logic bipolar);
		logic [3:0] uni;
		uni = 4'h0;
		unique case (idx)
			3'd0: uni = 4'b0001;
			3'd1: uni = 4'b0011;
			3'd2: uni = 4'b0010;
			3'd3: uni = 4'b0110;
			3'd4: uni = 4'b0100;
			3'd5: uni = 4'b1100;
			3'd6: uni = 4'b1000;
			3'd7: uni = 4'b1001;
		endcase
		// Bipolar: winding enables in bits 3:2, current directions in 1:0
		if (bipolar) begin
			phase_pattern = {uni[0] | uni[2], uni[1] | uni[3], uni[0], uni[1]};
		end else begin
			phase_pattern = uni;
		end
	endfunction

	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] meta_r;
	logic [SYNC_W-1:0] sync_r;
	assign raw = {gp_io_one_in, gp_io_zero_in, drive_style_pin_in,
		minus_limit_polarity_pin_in, plus_limit_polarity_pin_in,
		polarity_scheme_pin_in, settle_or_half_in, halt_request_pin_in,
		ext_go_pin_in, home_switch_in, minus_limit_switch_in,
		plus_limit_switch_in};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge clk_sys_in) begin
				if (!reset_n_in) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= raw[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	mitl_cfg_s cfg_r;
	logic [15:0] count_r;
	logic [5:0] gpio_r;
	mitl_state_e state_r;
	logic [15:0] left_r;
	logic [2:0] phase_idx_r;
	logic [3:0] filt_cnt_r;
	logic go_filt_r;
	logic go_filt_prev_r;
	logic home_prev_r;
	logic [7:0] emit_cnt_r;
	logic [7:0] clr_cnt_r;
	logic pulse_r;
	logic refused_r;
	logic [2:0] cause_r;

	logic wr_acc, rd_acc, mapped;
	logic start_cmd, stop_cmd, emit_cmd;
	logic timer_mode, phase_mode, half_step, bipolar;
	logic plus_act, minus_act, home_act, halt_act, settled_act;
	logic lim_dir, home_rise, home_fall, go_fall;
	logic refuse, run_stop, halt_hit, immediate_stop;
	logic [3:0] phases;
	logic [31:0] status_word;
	logic [31:0] rd_data;

	assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;
	assign rd_acc = psel_in & penable_in & !pready_out & !pwrite_in;
	assign mapped = (paddr_in == `MITL_OFF_CMD) || (paddr_in == `MITL_OFF_CFG)
		|| (paddr_in == `MITL_OFF_COUNT) || (paddr_in == `MITL_OFF_STATUS)
		|| (paddr_in == `MITL_OFF_GPIO);
	assign start_cmd = wr_acc && paddr_in == `MITL_OFF_CMD
		&& pwdata_in[`MITL_CMD_START];
	assign stop_cmd = wr_acc && paddr_in == `MITL_OFF_CMD
		&& pwdata_in[`MITL_CMD_STOP];
	assign emit_cmd = wr_acc && paddr_in == `MITL_OFF_CMD
		&& pwdata_in[`MITL_CMD_EMIT];

	assign timer_mode = cfg_r.operation_kind_field == `MITL_KIND_TIMER;
	assign phase_mode = sync_r[9];
	assign half_step = phase_mode & sync_r[5];
	assign bipolar = sync_r[6];
	// polarity pins invert the limit inputs
	assign plus_act = sync_r[0] ^ sync_r[7];
	assign minus_act = sync_r[1] ^ sync_r[8];
	assign home_act = sync_r[2] ^ cfg_r.home_pin_polarity;
	// halt gated by enable, level by polarity
	assign halt_act = cfg_r.halt_pin_enable
		& (sync_r[4] ^ cfg_r.halt_pin_polarity);
	assign settled_act = sync_r[5] ^ cfg_r.settled_pin_polarity;
	assign lim_dir = !timer_mode
		& (cfg_r.dir_minus ? minus_act : plus_act);
	// home stop only on edges seen during motion
	assign home_rise = home_act & !home_prev_r;
	assign home_fall = !home_act & home_prev_r;
	assign go_fall = !go_filt_r & go_filt_prev_r;
	// refuse on limit, on halt, on home off
	assign refuse = lim_dir | halt_act
		| (cfg_r.operation_kind_field == `MITL_KIND_LEAVE && !home_act);
	assign halt_hit = halt_act & !cfg_r.halt_style_select;
	assign immediate_stop = stop_cmd | lim_dir | halt_hit
		| ((cfg_r.operation_kind_field == `MITL_KIND_HOME1
		|| cfg_r.operation_kind_field == `MITL_KIND_HOME2) && home_rise)
		| (cfg_r.operation_kind_field == `MITL_KIND_LEAVE && home_fall);
	assign run_stop = immediate_stop
		| (decel_req_out & ramp_done_in)
		| (count_r != 16'h0000 && left_r == 16'h0000);
	assign phases = phase_pattern(phase_idx_r, bipolar);

	// live pin levels in status word
	assign status_word = {13'h0000, cause_r, refused_r, 1'b0, state_r,
		phases, shared_role_pin_out, bipolar, sync_r[5], sync_r[4],
		sync_r[2], sync_r[1], sync_r[0], go_filt_r};

	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr_in)
			`MITL_OFF_CFG: rd_data = {16'h0000, cfg_r};
			`MITL_OFF_COUNT: rd_data = {16'h0000, count_r};
			`MITL_OFF_STATUS: rd_data = status_word;
			`MITL_OFF_GPIO: rd_data = {22'h00_0000, sync_r[11:10], 2'b00,
				gpio_r};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// One wait state: answer registered in the second access cycle
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else begin
			pready_out <= psel_in & penable_in & !pready_out;
			pslverr_out <= psel_in & penable_in & !pready_out & !mapped;
			if (rd_acc) begin
				prdata_out <= rd_data;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			cfg_r <= mitl_cfg_s'(16'(`MITL_CFG_RESET));
			count_r <= 16'(`MITL_COUNT_RESET);
			gpio_r <= 6'(`MITL_GPIO_RESET);
		end else if (wr_acc) begin
			if (paddr_in == `MITL_OFF_CFG) begin
				cfg_r <= mitl_cfg_s'(pwdata_in[15:0]);
			end
			if (paddr_in == `MITL_OFF_COUNT) begin
				count_r <= pwdata_in[15:0];
			end
			if (paddr_in == `MITL_OFF_GPIO) begin
				gpio_r <= pwdata_in[5:0];
			end
		end
	end

	// go level changes only after five equal samples
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			filt_cnt_r <= 4'h0;
			go_filt_r <= 1'b1;
			go_filt_prev_r <= 1'b1;
		end else begin
			go_filt_prev_r <= go_filt_r;
			if (sync_r[3] == go_filt_r) begin
				filt_cnt_r <= 4'h0;
			end else if (filt_cnt_r == FILT_MAX - 4'h1) begin
				filt_cnt_r <= 4'h0;
				go_filt_r <= sync_r[3];
			end else begin
				filt_cnt_r <= filt_cnt_r + 4'h1;
			end
		end
	end

	// open-drain one-shot, only ever pulls low
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			emit_cnt_r <= 8'h00;
			ext_go_pin_out <= 1'b0;
			ext_go_pin_oe_out <= 1'b0;
		end else begin
			ext_go_pin_out <= 1'b0;
			if (emit_cmd) begin
				emit_cnt_r <= GO_PULSE;
				ext_go_pin_oe_out <= 1'b1;
			end else if (emit_cnt_r > 8'h01) begin
				emit_cnt_r <= emit_cnt_r - 8'h01;
			end else begin
				emit_cnt_r <= 8'h00;
				ext_go_pin_oe_out <= 1'b0;
			end
		end
	end

	// Motion sequencer
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_r <= MITL_IDLE;
			left_r <= 16'h0000;
			home_prev_r <= 1'b0;
			refused_r <= 1'b0;
			cause_r <= 3'b000;
			decel_req_out <= 1'b0;
			busy_out <= 1'b0;
		end else begin
			home_prev_r <= home_act;
			unique case (state_r)
				MITL_IDLE: begin
					if (start_cmd && refuse) begin
						refused_r <= 1'b1;
					end else if (start_cmd) begin
						refused_r <= 1'b0;
						cause_r <= 3'b000;
						left_r <= count_r;
						busy_out <= 1'b1;
						state_r <= cfg_r.sync_launch_enable ? MITL_WAIT_GO
							: MITL_RUN;
					end
				end
				MITL_WAIT_GO: begin
					if (stop_cmd) begin
						busy_out <= 1'b0;
						state_r <= MITL_IDLE;
					end else if (go_fall) begin
						if (refuse) begin
							refused_r <= 1'b1;
							busy_out <= 1'b0;
							state_r <= MITL_IDLE;
						end else begin
							state_r <= MITL_RUN;
						end
					end
				end
				MITL_RUN: begin
					if (step_in && left_r != 16'h0000) begin
						left_r <= left_r - 16'h0001;
					end
					if (halt_act && cfg_r.halt_style_select) begin
						decel_req_out <= 1'b1;
					end
					if (run_stop) begin
						decel_req_out <= 1'b0;
						cause_r <= cause_r | {halt_act, home_rise | home_fall,
							lim_dir};
						// wait for settled input after pulses
						if (!immediate_stop && cfg_r.inpos_wait && !phase_mode)
						begin
							state_r <= MITL_SETTLE;
						end else begin
							busy_out <= 1'b0;
							state_r <= MITL_IDLE;
						end
					end
				end
				MITL_SETTLE: begin
					if (settled_act || stop_cmd) begin
						busy_out <= 1'b0;
						state_r <= MITL_IDLE;
					end
				end
			endcase
		end
	end

	// no pulse, no phase advance in timer kind
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			pulse_r <= 1'b0;
			phase_idx_r <= 3'd0;
		end else begin
			pulse_r <= state_r == MITL_RUN && step_in && !run_stop
				&& !timer_mode;
			// half step moves one index, full step two
			if (state_r == MITL_RUN && step_in && !run_stop && !timer_mode)
			begin
				if (cfg_r.dir_minus) begin
					phase_idx_r <= phase_idx_r - (half_step ? 3'd1 : 3'd2);
				end else begin
					phase_idx_r <= phase_idx_r + (half_step ? 3'd1 : 3'd2);
				end
			end else if (!half_step && !phase_idx_r[0]) begin
				// Full step keeps two windings on
				phase_idx_r <= phase_idx_r + 3'd1;
			end
		end
	end

	// Deviation clear pulse on abrupt stops, cutback while idle
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			clr_cnt_r <= 8'h00;
		end else if (state_r == MITL_RUN && immediate_stop) begin
			clr_cnt_r <= CLR_PULSE;
		end else if (clr_cnt_r != 8'h00) begin
			clr_cnt_r <= clr_cnt_r - 8'h01;
		end
	end

	// Pin drivers, all registered
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			pulse_or_phase_a_out <= 1'b0;
			dir_or_phase_b_out <= 1'b0;
			gp_two_or_phase_c_out <= 1'b0;
			gp_three_or_phase_d_out <= 1'b0;
			shared_role_pin_out <= 1'b0;
			gp_io_zero_out <= 1'b0;
			gp_io_zero_oe_out <= 1'b0;
			gp_io_one_out <= 1'b0;
			gp_io_one_oe_out <= 1'b0;
		end else begin
			if (phase_mode) begin
				{gp_three_or_phase_d_out, gp_two_or_phase_c_out,
					dir_or_phase_b_out, pulse_or_phase_a_out} <= phases;
			end else begin
				// bit2 two-pulse, bit1 dir invert, bit0 pulse invert
				if (cfg_r.pulse_format_field[2]) begin
					pulse_or_phase_a_out <= cfg_r.pulse_format_field[0]
						^ (pulse_r & !cfg_r.dir_minus);
					dir_or_phase_b_out <= cfg_r.pulse_format_field[1]
						^ (pulse_r & cfg_r.dir_minus);
				end else begin
					pulse_or_phase_a_out <= cfg_r.pulse_format_field[0]
						^ pulse_r;
					dir_or_phase_b_out <= cfg_r.pulse_format_field[1]
						^ cfg_r.dir_minus;
				end
				gp_two_or_phase_c_out <= gpio_r[4];
				gp_three_or_phase_d_out <= gpio_r[5];
			end
			shared_role_pin_out <= cfg_r.clear_pin_polarity
				^ (cfg_r.shared_pin_role_select ? (state_r == MITL_IDLE)
				: (clr_cnt_r != 8'h00));
			gp_io_zero_oe_out <= gpio_r[0];
			gp_io_one_oe_out <= gpio_r[1];
			gp_io_zero_out <= gpio_r[2];
			gp_io_one_out <= gpio_r[3];
		end
	end
endmodule
`default_nettype wire

// ==== tb/mitl_terminal_chk.sv ====
// Port checker for the motion terminal block
`timescale 1ns/1ps
`default_nettype none
`include "mitl_defines.svh"
module mitl_terminal_chk (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic decel_req_out,
	input wire logic busy_out,
	input wire logic ext_go_pin_out,
	input wire logic ext_go_pin_oe_out,
	input wire logic gp_io_zero_oe_out,
	input wire logic gp_io_one_oe_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	logic [7:0] oe_len_r;
	// Counts consecutive cycles of the go pulse
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in || !ext_go_pin_oe_out)
			oe_len_r <= 8'h00;
		else
			oe_len_r <= oe_len_r + 8'h01;
	end
	sequence apb_done_s;
		psel_in && penable_in && pready_out && pwrite_in;
	endsequence
	sequence emit_wr_s;
		apb_done_s ##0 (paddr_in == `MITL_OFF_CMD
			&& pwdata_in[`MITL_CMD_EMIT]);
	endsequence
	ready_one_cycle_a: assert property (pready_out |=> !pready_out)
		else $error("ready held for more than one cycle");
	err_with_ready_a: assert property (pslverr_out |-> pready_out)
		else $error("error flag without ready");
	go_never_high_a: assert property (!ext_go_pin_out)
		else $error("go pin driven high");
	emit_follows_a: assert property (emit_wr_s |-> ##[1:3] ext_go_pin_oe_out)
		else $error("emit command gave no go pulse");
	emit_width_a: assert property ($fell(ext_go_pin_oe_out) |->
		oe_len_r == 8'(`MITL_GO_PULSE_CYC))
		else $error("go pulse width wrong");
	gp_dir_write_a: assert property (($changed(gp_io_zero_oe_out) ||
		$changed(gp_io_one_oe_out)) |-> $past(psel_in && penable_in &&
		pready_out && pwrite_in && paddr_in == `MITL_OFF_GPIO, 2))
		else $error("gp direction changed without a write");
	busy_cause_a: assert property ($rose(busy_out) |->
		$past(psel_in && pready_out && paddr_in == `MITL_OFF_CMD) ||
		$past(psel_in && pready_out && paddr_in == `MITL_OFF_CMD, 2))
		else $error("busy rose without a command");
	decel_busy_a: assert property (decel_req_out |-> busy_out)
		else $error("deceleration request while idle");
endmodule
bind mitl_terminal mitl_terminal_chk chk_u (.clk_sys_in, .reset_n_in,
	.psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out,
	.pslverr_out, .decel_req_out, .busy_out, .ext_go_pin_out,
	.ext_go_pin_oe_out, .gp_io_zero_oe_out, .gp_io_one_oe_out);
`default_nettype wire

// ==== tb/mitl_env_model.sv ====
// Far side: limit switches and the pulled-up shared lines
`timescale 1ns/1ps
`default_nettype none
module mitl_env_model (
	input wire logic plus_act_in,
	input wire logic minus_act_in,
	input wire logic plus_pol_in,
	input wire logic minus_pol_in,
	input wire logic other_go_in,
	input wire logic go_oe_in,
	input wire logic gp0_oe_in,
	input wire logic gp0_in,
	input wire logic gp1_oe_in,
	input wire logic gp1_in,
	output logic plus_pin_out,
	output logic minus_pin_out,
	output logic go_line_out,
	output logic gp0_line_out,
	output logic gp1_line_out
);
	// Strap high turns the switch into an active-low contact
	assign plus_pin_out = plus_act_in ^ plus_pol_in;
	assign minus_pin_out = minus_act_in ^ minus_pol_in;
	// open drain line
	// Parties only pull low; the resistor restores high
	assign go_line_out = !(go_oe_in || other_go_in);
	// Board pull-ups hold released gp pins high
	assign gp0_line_out = gp0_oe_in ? gp0_in : 1'h1;
	assign gp1_line_out = gp1_oe_in ? gp1_in : 1'h1;
endmodule
`default_nettype wire

// ==== tb/mitl_terminal_tb.sv ====
// Bench: pin and register scenarios for the terminal block
`timescale 1ns/1ps
`default_nettype none
`include "mitl_defines.svh"
module mitl_terminal_tb;
	import mitl_pkg::*;
	logic clk_sys_in = 1'h0, reset_n_in = 1'h0, psel = 1'h0, pen = 1'h0;
	logic pwr = 1'h0, step = 1'h0, ramp = 1'h0, pl_act = 1'h0;
	logic mi_act = 1'h0, pl_pol = 1'h0, mi_pol = 1'h0, home = 1'h0;
	logic halt = 1'h0, other = 1'h0, style = 1'h0, scheme = 1'h0;
	logic settle = 1'h0, idle_a = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, err_v, decel, busy, pl_pin, mi_pin, go_line;
	logic go_o, go_oe, a, b, c, d, shared, g0o, g0oe, g1o, g1oe, g0l, g1l;
	int error_cnt = 0, tests_run = 0, pulses = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	mitl_terminal dut_u (.clk_sys_in, .reset_n_in, .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .step_in(step), .ramp_done_in(ramp),
		.decel_req_out(decel), .busy_out(busy),
		.plus_limit_switch_in(pl_pin), .minus_limit_switch_in(mi_pin),
		.plus_limit_polarity_pin_in(pl_pol),
		.minus_limit_polarity_pin_in(mi_pol), .home_switch_in(home),
		.ext_go_pin_in(go_line), .ext_go_pin_out(go_o),
		.ext_go_pin_oe_out(go_oe), .halt_request_pin_in(halt),
		.drive_style_pin_in(style), .polarity_scheme_pin_in(scheme),
		.settle_or_half_in(settle), .pulse_or_phase_a_out(a),
		.dir_or_phase_b_out(b), .gp_two_or_phase_c_out(c),
		.gp_three_or_phase_d_out(d), .shared_role_pin_out(shared),
		.gp_io_zero_in(g0l), .gp_io_zero_out(g0o), .gp_io_zero_oe_out(g0oe),
		.gp_io_one_in(g1l), .gp_io_one_out(g1o), .gp_io_one_oe_out(g1oe));
	mitl_env_model env_u (.plus_act_in(pl_act), .minus_act_in(mi_act),
		.plus_pol_in(pl_pol), .minus_pol_in(mi_pol), .other_go_in(other),
		.go_oe_in(go_oe), .gp0_oe_in(g0oe), .gp0_in(g0o), .gp1_oe_in(g1oe),
		.gp1_in(g1o), .plus_pin_out(pl_pin), .minus_pin_out(mi_pin),
		.go_line_out(go_line), .gp0_line_out(g0l), .gp1_line_out(g1l));
	// Any cycle away from the idle level is one output pulse
	always @(posedge clk_sys_in) if (a !== idle_a) pulses = pulses + 1;
	task automatic summarize;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Request held until the edge that samples ready high
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, output logic [31:0] rd);
		{psel, pwr, paddr, pwdata} <= {1'h1, w, ad, wd};
		@(posedge clk_sys_in);
		pen <= 1'h1;
		// No cycle budget here; only the watchdog ends a hung wait
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'h1);
		rd = prdata;
		err_v = pslverr;
		{psel, pen} <= 2'h0;
		@(posedge clk_sys_in);
	endtask
	task automatic steps(input int n);
		repeat (n) begin
			step <= 1'h1;
			@(posedge clk_sys_in);
			step <= 1'h0;
			cyc(4);
		end
	endtask
	task automatic go(input logic [15:0] cf, input logic [15:0] cn);
		apb(1'h1, `MITL_OFF_CFG, {16'h0000, cf}, q);
		apb(1'h1, `MITL_OFF_COUNT, {16'h0000, cn}, q);
		apb(1'h1, `MITL_OFF_CMD, 32'h0000_0001, q);
		cyc(3);
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, `MITL_OFF_STATUS, 32'h0000_0000, q);
		chk(q & m, e);
	endtask
	initial begin
		#2_000_000;
		error_cnt++;
		summarize();
	end
	initial begin
		cyc(5);
		reset_n_in <= 1'h1;
		cyc(2);
		apb(1'h0, `MITL_OFF_CFG, 32'h0000_0000, q);
		chk(q, `MITL_CFG_RESET);
		apb(1'h0, 8'h40, 32'h0000_0000, q);
		chk({q[30:0], err_v}, 32'h0000_0001);
		for (int f = 0; f < 8; f++) begin
			idle_a <= f[0];
			go(16'(f << 9), 16'h0002);
			pulses = 0;
			steps(2);
			chk(pulses, 2);
			chk(busy, 0);
			chk(b, f[1]);
		end
		idle_a <= 1'h0;
		pl_pol <= 1'h1;
		pl_act <= 1'h1;
		go(16'h0000, 16'h0000);
		chk(busy, 0);
		stat(32'h0000_8000, 32'h0000_8000);
		go(16'h0004, 16'h0002);
		pulses = 0;
		steps(2);
		chk(pulses, 0);
		stat(32'h0000_8000, 32'h0000_0000);
		go(16'h0008, 16'h0000);
		chk(busy, 1);
		chk(b, 1'h1);
		mi_act <= 1'h1;
		pl_act <= 1'h0;
		cyc(6);
		chk(busy, 0);
		chk(shared, 1);
		mi_act <= 1'h0;
		cyc(5);
		chk(busy, 0);
		stat(32'h0007_0000, 32'h0001_0000);
		for (int k = 1; k < 3; k++) begin
			home <= 1'h1;
			go(16'(k), 16'h0000);
			home <= 1'h0;
			cyc(5);
			chk(busy, 1);
			home <= 1'h1;
			cyc(6);
			chk(busy, 0);
			home <= 1'h0;
		end
		go(16'h0003, 16'h0000);
		chk(busy, 0);
		home <= 1'h1;
		go(16'h0003, 16'h0000);
		chk(busy, 1);
		home <= 1'h0;
		cyc(6);
		chk(busy, 0);
		go(16'h0010, 16'h0000);
		stat(32'h0000_3000, 32'h0000_1000);
		other <= 1'h1;
		cyc(4);
		other <= 1'h0;
		cyc(8);
		stat(32'h0000_3000, 32'h0000_1000);
		apb(1'h1, `MITL_OFF_CMD, 32'h0000_0004, q);
		cyc(2);
		chk(go_line, 0);
		cyc(30);
		chk(go_line, 1);
		stat(32'h0000_3000, 32'h0000_2000);
		halt <= 1'h1;
		apb(1'h1, `MITL_OFF_CMD, 32'h0000_0002, q);
		go(16'h0000, 16'h0000);
		chk(busy, 1);
		apb(1'h1, `MITL_OFF_CMD, 32'h0000_0002, q);
		go(16'h0020, 16'h0000);
		chk(busy, 0);
		halt <= 1'h0;
		go(16'h0060, 16'h0000);
		halt <= 1'h1;
		cyc(5);
		chk({decel, busy}, 3);
		ramp <= 1'h1;
		cyc(1);
		ramp <= 1'h0;
		cyc(3);
		chk(busy, 0);
		halt <= 1'h0;
		cyc(5);
		chk(busy, 0);
		go(16'h8000, 16'h0001);
		steps(1);
		chk(busy, 1);
		settle <= 1'h1;
		cyc(5);
		chk(busy, 0);
		apb(1'h1, `MITL_OFF_CFG, 32'h0000_1000, q);
		cyc(2);
		chk(shared, 1);
		apb(1'h1, `MITL_OFF_CFG, 32'h0000_3000, q);
		cyc(2);
		chk(shared, 0);
		apb(1'h1, `MITL_OFF_GPIO, 32'h0000_0019, q);
		cyc(4);
		chk({g0oe, g0o, g1oe, g1o, c, d}, 6'h26);
		apb(1'h0, `MITL_OFF_GPIO, 32'h0000_0000, q);
		chk(q & 32'h0000_0300, 32'h0000_0200);
		scheme <= 1'h1;
		home <= 1'h1;
		cyc(4);
		stat(32'h0000_007F, 32'h0000_006B);
		// Four-phase pins: winding counts per step, frozen in timer kind
		style <= 1'h1;
		scheme <= 1'h0;
		for (int h = 0; h < 2; h++) begin
			settle <= h[0];
			go(16'h0000, 16'h0004);
			q = {28'h000_0000, d, c, b, a};
			for (int s = 0; s < 4; s++) begin
				steps(1);
				chk({d, c, b, a} == q[3:0], 0);
				chk($countones({d, c, b, a, q[3:0]}), h ? 3 : 4);
				q = {28'h000_0000, d, c, b, a};
			end
		end
		go(16'h0004, 16'h0002);
		q = {28'h000_0000, d, c, b, a};
		steps(2);
		chk({d, c, b, a}, q);
		scheme <= 1'h1;
		settle <= 1'h0;
		cyc(6);
		chk({d, c}, 2'h3);
		stat(32'h0000_0F00, {20'h0_0000, d, c, b, a, 8'h00});
		summarize();
	end
endmodule
`default_nettype wire
